/* File: adc_frame_pkg.sv */
// constants, carrier types and command decoding for the serial frame engine
package adc_frame_pkg;

  // ----------------------------------------------------------------------
  // frame counting and widths
  // ----------------------------------------------------------------------
  localparam int         WORD_W     = 32;
  localparam int         CNT_W      = 6;
  localparam logic [5:0] OPT_EDGES  = 6'h20;   // 32 capture edges
  localparam logic [5:0] CNT_MAX    = 6'h3f;   // counter saturates here
  localparam int         HALF_AW    = 7;       // 128 register pairs
  localparam int         HALF_DEPTH = 128;
  localparam int         LANES      = 2;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0]  PINS_IDLE = 3'h4;    // select high, clock low
  localparam logic        RDY_RST   = 1'b1;
  localparam logic [31:0] CMD_NOP   = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // command encodings
  // ----------------------------------------------------------------------
  localparam logic [4:0] OP_CLEAR_HALF = 5'h18;  // 11000
  localparam logic [4:0] OP_READ_HALF  = 5'h19;  // 11001
  localparam logic [4:0] OP_READ_BYTE  = 5'h09;  // 01001
  localparam logic [4:0] OP_WRITE      = 5'h1a;  // 11010
  localparam logic [4:0] OP_SET_HALF   = 5'h1b;  // 11011
  localparam logic [1:0] WR_BOTH       = 2'h0;
  localparam logic [1:0] WR_UPPER      = 2'h1;
  localparam logic [1:0] WR_LOWER      = 2'h2;

  // ----------------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [4:0]  opcode;
    logic [1:0]  qual;
    logic [8:0]  addr;
    logic [15:0] data;
  } cmd_word_type;

  typedef struct packed {
    logic cs;
    logic sclk;
    logic sdi;
  } pins_type;

  typedef struct packed {
    logic        done;
    logic [15:0] result;
  } conv_out_type;

  typedef enum logic [2:0] {
    k_nop, k_clear, k_set, k_read_half, k_read_byte, k_wr_both, k_wr_upper, k_wr_lower
  } cmd_kind_type;

  typedef enum logic [1:0] {sel_conv, sel_byte, sel_half} out_sel_type;

  // decodes a held command word into its kind
  function automatic cmd_kind_type decode_cmd(input cmd_word_type c);
    cmd_kind_type k;
    k = k_nop;
    if (!c.addr[8]) begin
      unique case (c.opcode)
        OP_CLEAR_HALF: k = k_clear;
        OP_SET_HALF:   k = k_set;
        OP_READ_HALF:  k = (c.data == 16'h0000) ? k_read_half : k_nop;
        OP_READ_BYTE:  k = (c.data == 16'h0000) ? k_read_byte : k_nop;
        OP_WRITE: begin
          if (c.qual == WR_BOTH) k = k_wr_both;
          else if (c.qual == WR_UPPER) k = k_wr_upper;
          else if (c.qual == WR_LOWER) k = k_wr_lower;
          else k = k_nop;
        end
        default:       k = k_nop;
      endcase
    end
    return k;
  endfunction : decode_cmd

endpackage : adc_frame_pkg

/* File: reg_half_mem.sv */
// register pair store with byte write enables and registered read data
`timescale 1ns/10ps
`default_nettype none
module reg_half_mem (
  // clock and reset
  input  wire  logic                              ref_clk,
  input  wire  logic                              rst_b,
  // access port
  input  wire  logic [adc_frame_pkg::HALF_AW-1:0] addr,
  input  wire  logic                              wr_en,
  input  wire  logic [1:0]                        byte_en,
  input  wire  logic [15:0]                       wdata,
  output logic       [15:0]                       rdata
);

  // ----------------------------------------------------------------------
  // storage and read flops, one generate slice per byte lane
  // ----------------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_lane
      logic [7:0] lane_r [adc_frame_pkg::HALF_DEPTH];

      // each lane owns its own bytes, so no array has two writers
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          for (int i = 0; i < adc_frame_pkg::HALF_DEPTH; i++) begin
            lane_r[i] <= 8'h00;
          end
        end else if (wr_en && byte_en[b]) begin
          lane_r[addr] <= wdata[8*b +: 8];
        end
      end

      // registered read port of this lane
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          rdata[8*b +: 8] <= 8'h00;
        end else begin
          rdata[8*b +: 8] <= lane_r[addr];
        end
      end
    end
  endgenerate

endmodule : reg_half_mem
`default_nettype wire

/* File: adc_serial_frame_cmd_decoder.sv */
// serial frame engine and command decoder of the converter host port
`timescale 1ns/10ps
`default_nettype none
module adc_serial_frame_cmd_decoder (
  // clock and reset
  input  wire  logic                             ref_clk,
  input  wire  logic                             rst_b,
  // host pins
  input  wire  logic                             conv_start_select,
  input  wire  logic                             sclk_in,
  input  wire  logic                             sdi_in,
  output logic       [adc_frame_pkg::LANES-1:0]  serial_out_lanes,
  output logic       [adc_frame_pkg::LANES-1:0]  serial_out_oe,
  output logic                                   ready_status_out,
  // converter core
  input  wire  adc_frame_pkg::conv_out_type      conv_in,
  output logic                                   conv_start,
  // output word setup
  input  wire  logic [adc_frame_pkg::LANES-1:0]  lane_en,
  input  wire  logic                             fixed_pat_en,
  input  wire  logic [31:0]                      fixed_pat
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  adc_frame_pkg::pins_type     pin_s1_r;
  adc_frame_pkg::pins_type     pin_s2_r;
  adc_frame_pkg::pins_type     pin_s3_r;
  adc_frame_pkg::cmd_word_type cmd_r;
  adc_frame_pkg::cmd_kind_type cmd_kind;
  adc_frame_pkg::out_sel_type  out_sel_r;
  logic                        cs_fall;
  logic                        cs_rise;
  logic                        sclk_rise;
  logic                        sclk_fall;
  logic                        frame_start;
  logic                        frame_end;
  logic                        frame_r;
  logic                        conv_busy_r;
  logic                        rdy_r;
  logic                        conv_start_r;
  logic                        cmd_go_r;
  logic [5:0]                  edge_cnt_r;
  logic [31:0]                 in_shift_r;
  logic [31:0]                 osr_r;
  logic [31:0]                 next_word;
  logic [1:0]                  out_oe_r;
  logic [15:0]                 conv_result_r;
  logic [15:0]                 rd_word_r;
  logic                        mem_we;
  logic [1:0]                  mem_be;
  logic [15:0]                 mem_wdata;
  logic [15:0]                 mem_rdata;

  typedef enum logic {st_idle, st_apply} exec_state_type;
  exec_state_type exec_r;

  // ----------------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  // two flops before use, a third only to find edges
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_r <= adc_frame_pkg::PINS_IDLE;
      pin_s2_r <= adc_frame_pkg::PINS_IDLE;
      pin_s3_r <= adc_frame_pkg::PINS_IDLE;
    end else begin
      pin_s1_r <= {conv_start_select, sclk_in, sdi_in};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // edges of select and serial clock
  assign cs_fall   = pin_s3_r.cs & ~pin_s2_r.cs;
  assign cs_rise   = ~pin_s3_r.cs & pin_s2_r.cs;
  assign sclk_rise = ~pin_s3_r.sclk & pin_s2_r.sclk;   // capture edge
  assign sclk_fall = pin_s3_r.sclk & ~pin_s2_r.sclk;   // launch edge

  // select edges seen during conversion are ignored
  assign frame_start = cs_fall & ~conv_busy_r & ~frame_r;
  assign frame_end   = cs_rise & frame_r;

  // ----------------------------------------------------------------------
  // frame and conversion state
  // ----------------------------------------------------------------------
  // frame window from select fall to select rise
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_r <= 1'b0;
    end else if (frame_start) begin
      frame_r <= 1'b1;
    end else if (frame_end) begin
      frame_r <= 1'b0;
    end
  end

  // conversion runs from frame end until the core reports done
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_busy_r  <= 1'b0;
      conv_start_r <= 1'b0;
    end else begin
      conv_start_r <= frame_end;
      if (frame_end) begin
        conv_busy_r <= 1'b1;
      end else if (conv_in.done) begin
        conv_busy_r <= 1'b0;
      end
    end
  end

  // ready status output
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdy_r <= adc_frame_pkg::RDY_RST;
    // low at frame start and conversion start
    end else if (frame_start || frame_end) begin
      rdy_r <= 1'b0;
    end else if (conv_busy_r && conv_in.done) begin
      rdy_r <= 1'b1;
    end
  end

  // latest conversion result
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_result_r <= 16'h0000;
    end else if (conv_in.done) begin
      conv_result_r <= conv_in.result;
    end
  end

  assign ready_status_out = rdy_r;
  assign conv_start       = conv_start_r;

  // ----------------------------------------------------------------------
  // capture side: edge counter and input shift register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      edge_cnt_r <= 6'h00;
    end else if (frame_start) begin
      edge_cnt_r <= 6'h00;
    end else if (frame_r && sclk_rise && edge_cnt_r != adc_frame_pkg::CNT_MAX) begin
      edge_cnt_r <= edge_cnt_r + 6'h01;
    end
  end

  // bits taken only on host serial clock capture edges
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_shift_r <= 32'h0000_0000;
    end else if (frame_start) begin
      in_shift_r <= 32'h0000_0000;
    // shift into LSB, oldest bits fall off the top
    end else if (frame_r && sclk_rise) begin
      in_shift_r <= {in_shift_r[30:0], pin_s2_r.sdi};
    end
  end

  // ----------------------------------------------------------------------
  // launch side: output word and shift register
  // ----------------------------------------------------------------------
  // word for this frame chosen by the previous command, or the fixed pattern when that is enabled
  always_comb begin
    if (fixed_pat_en) begin
      next_word = fixed_pat;
    end else if (out_sel_r == adc_frame_pkg::sel_half) begin
      next_word = {rd_word_r, 16'h0000};
    end else if (out_sel_r == adc_frame_pkg::sel_byte) begin
      next_word = {rd_word_r[7:0], 24'h00_0000};
    end else begin
      next_word = {conv_result_r, 16'h0000};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      osr_r <= 32'h0000_0000;
    // load the prepared word at frame start
    end else if (frame_start) begin
      osr_r <= next_word;
    // advance on each launch edge, MSB first
    end else if (frame_r && sclk_fall) begin
      osr_r <= {osr_r[30:0], 1'b0};
    end
  end

  // lane enables held for the frame
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_oe_r <= 2'h0;
    end else if (frame_start) begin
      out_oe_r <= lane_en;
    // release the lanes at frame end
    end else if (frame_end) begin
      out_oe_r <= 2'h0;
    end
  end

  assign serial_out_lanes = {adc_frame_pkg::LANES{osr_r[31]}};
  assign serial_out_oe    = out_oe_r;

  // ----------------------------------------------------------------------
  // command holding register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_r    <= adc_frame_pkg::CMD_NOP;
      cmd_go_r <= 1'b0;
    end else begin
      cmd_go_r <= frame_end;
      if (frame_start) begin
        cmd_r <= adc_frame_pkg::CMD_NOP;
      // only frames of 32 or more edges carry a command
      end else if (frame_end) begin
        cmd_r <= (edge_cnt_r >= adc_frame_pkg::OPT_EDGES) ? in_shift_r : adc_frame_pkg::CMD_NOP;
      end
    end
  end

  assign cmd_kind = adc_frame_pkg::decode_cmd(cmd_r);

  // ----------------------------------------------------------------------
  // command execution
  // ----------------------------------------------------------------------
  // reads the pair right after frame end, applies it one cycle later
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      exec_r <= st_idle;
    end else begin
      unique case (exec_r)
        st_idle:  exec_r <= (cmd_go_r && cmd_kind != adc_frame_pkg::k_nop) ? st_apply : st_idle;
        st_apply: exec_r <= st_idle;
      endcase
    end
  end

  // write data and byte enables for the modifying commands
  always_comb begin
    mem_we    = 1'b0;
    mem_be    = 2'h3;
    mem_wdata = cmd_r.data;
    if (exec_r == st_apply) begin
      unique case (cmd_kind)
        adc_frame_pkg::k_clear: begin
          mem_we    = 1'b1;
          mem_wdata = mem_rdata & ~cmd_r.data;
        end
        adc_frame_pkg::k_set: begin
          mem_we    = 1'b1;
          mem_wdata = mem_rdata | cmd_r.data;
        end
        adc_frame_pkg::k_wr_both: begin
          mem_we = 1'b1;
        end
        adc_frame_pkg::k_wr_upper: begin
          mem_we = 1'b1;
          mem_be = 2'h2;
        end
        adc_frame_pkg::k_wr_lower: begin
          mem_we = 1'b1;
          mem_be = 2'h1;
        end
        default: begin
          mem_we = 1'b0;
        end
      endcase
    end
  end

  // read results steer the next output word
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_sel_r <= adc_frame_pkg::sel_conv;
      rd_word_r <= 16'h0000;
    end else if (frame_end) begin
      out_sel_r <= adc_frame_pkg::sel_conv;
    end else if (exec_r == st_apply && cmd_kind == adc_frame_pkg::k_read_half) begin
      out_sel_r <= adc_frame_pkg::sel_half;
      rd_word_r <= mem_rdata;
    // one byte picked by the address LSB
    end else if (exec_r == st_apply && cmd_kind == adc_frame_pkg::k_read_byte) begin
      out_sel_r <= adc_frame_pkg::sel_byte;
      rd_word_r <= {8'h00, cmd_r.addr[0] ? mem_rdata[15:8] : mem_rdata[7:0]};
    end
  end

  // pair index drops the address LSB
  reg_half_mem u_regs (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .addr    (cmd_r.addr[7:1]),
    .wr_en   (mem_we),
    .byte_en (mem_be),
    .wdata   (mem_wdata),
    .rdata   (mem_rdata)
  );

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_start_rdy_low: assert property (frame_start |=> !ready_status_out)
    else $error("ready not low after frame start");
  a_start_cnt_clear: assert property (frame_start |=> edge_cnt_r == 6'h00)
    else $error("edge counter not cleared at frame start");
  a_start_osr_load: assert property (frame_start |=> osr_r == $past(next_word)
    && serial_out_oe == $past(lane_en))
    else $error("output word or lanes not taken at frame start");
  a_start_cmd_nop: assert property (frame_start |=> cmd_r == 32'h0000_0000)
    else $error("command not cleared at frame start");
  a_capture_shift: assert property (frame_r && sclk_rise && !frame_end |=>
    in_shift_r == {$past(in_shift_r[30:0]), $past(pin_s2_r.sdi)})
    else $error("input bit not shifted into LSB");
  a_launch_shift: assert property (frame_r && sclk_fall && !frame_start |=>
    osr_r == {$past(osr_r[30:0]), 1'b0})
    else $error("output register did not advance");
  a_end_release: assert property (frame_end |=> serial_out_oe == 2'h0
    && !ready_status_out && conv_start ##1 !conv_start)
    else $error("lanes not released or conversion not started");
  a_short_nop: assert property (frame_end && edge_cnt_r < 6'h20 |=>
    cmd_r == 32'h0000_0000)
    else $error("short frame left a command");
  a_full_cmd: assert property (frame_end && edge_cnt_r >= 6'h20 |=>
    cmd_r == $past(in_shift_r))
    else $error("last 32 bits not taken as command");
  a_apply_timing: assert property (cmd_go_r && cmd_kind == adc_frame_pkg::k_set
    |=> mem_we && mem_be == 2'h3)
    else $error("set command not applied one cycle after decode");

  c_optimal: cover property (frame_end && edge_cnt_r == 6'h20);
  c_short: cover property (frame_end && edge_cnt_r < 6'h20);
  c_long: cover property (frame_end && edge_cnt_r > 6'h20);
  c_read_half: cover property (exec_r == st_apply && cmd_kind == adc_frame_pkg::k_read_half);

endmodule : adc_serial_frame_cmd_decoder
`default_nettype wire

/* File: host_frame_model.sv */
// host controller model that drives the select, serial clock and data pins
`timescale 1ns/10ps
`default_nettype none
module host_frame_model (
  // clock
  input  wire  logic ref_clk,
  // device pins
  input  wire  logic ready_status_out,
  input  wire  logic lane_in,
  output logic       conv_start_select,
  output logic       sclk_in,
  output logic       sdi_in
);

  logic [31:0] fill = 32'h5a5a_0f0f;  // leading bits of long frames

  // ----------------------------------------------------------------------
  // pins idle: select high, clock low
  // ----------------------------------------------------------------------
  initial begin
    conv_start_select = 1'b1;
    sclk_in           = 1'b0;
    sdi_in            = 1'b0;
  end

  // one serial clock level lasts four system clocks, 100 ns
  task automatic half_period();
    repeat (4) @(posedge ref_clk);
  endtask : half_period

  // one frame of n capture edges; rx holds the leading output bits, msb aligned
  task automatic run_frame(input logic [31:0] cmd, input int n, output logic [31:0] rx);
    int i;
    rx = 32'h0;
    while (ready_status_out !== 1'b1) @(posedge ref_clk);
    conv_start_select <= 1'b0;
    for (i = 0; i < n; i++) begin
      // command msb first in the last 32 bits
      sdi_in <= (n - i > 32) ? fill[i % 32] : cmd[n - 1 - i];
      half_period();
      sclk_in <= 1'b1;
      half_period();
      // bit taken just before the next launch edge
      if (i < 32) rx = {rx[30:0], lane_in};
      sclk_in <= 1'b0;
    end
    half_period();
    conv_start_select <= 1'b1;
    sdi_in            <= ~sdi_in;  // released data line shows no stale bit
    if (n < 32) rx = rx << (32 - n);
  endtask : run_frame

endmodule : host_frame_model
`default_nettype wire

/* File: adc_serial_frame_cmd_decoder_test.sv */
// self-checking bench of the serial frame engine and command decoder
`timescale 1ns/10ps
`default_nettype none
module adc_serial_frame_cmd_decoder_test;

  logic                         ref_clk = 1'b0;
  logic                         rst_b;
  wire  logic                   cs_pin;
  wire  logic                   sclk_pin;
  wire  logic                   sdi_pin;
  logic [1:0]                   serial_out_lanes;
  logic [1:0]                   serial_out_oe;
  logic                         ready_status_out;
  adc_frame_pkg::conv_out_type  conv_in;
  logic                         conv_start;
  logic [1:0]                   lane_en;
  logic                         fixed_pat_en;
  logic [31:0]                  fixed_pat;
  logic [15:0]                  mem [128];
  logic [31:0]                  rdw, cmd, rx, exp, mask, fpat, r;
  logic [15:0]                  last_res = 16'h0;
  logic [4:0]                   cdly = 5'h0;
  logic [4:0]                   ops [8] = '{5'h18, 5'h1b, 5'h19, 5'h09, 5'h1a, 5'h1a, 5'h00, 5'h1f};
  int                           lens [5] = '{32, 32, 32, 20, 41};
  int                           seed, k, n, m, failures = 0, n_compared = 0, cyc = 0;
  logic                         rd_ok = 1'b0, fp_en;

  always #12.5 ref_clk = ~ref_clk;

  // a lane the design has not taken over shows the inverse of its data
  wire  logic lane_seen = serial_out_oe[lane_en[0] ? 0 : 1] ? serial_out_lanes[lane_en[0] ? 0 : 1]
                                                            : ~serial_out_lanes[lane_en[0] ? 0 : 1];

  adc_serial_frame_cmd_decoder u_adc_serial_frame_cmd_decoder (
    .ref_clk(ref_clk), .rst_b(rst_b), .conv_start_select(cs_pin), .sclk_in(sclk_pin),
    .sdi_in(sdi_pin), .serial_out_lanes(serial_out_lanes), .serial_out_oe(serial_out_oe),
    .ready_status_out(ready_status_out), .conv_in(conv_in), .conv_start(conv_start),
    .lane_en(lane_en), .fixed_pat_en(fixed_pat_en), .fixed_pat(fixed_pat));

  host_frame_model u_host_frame_model (
    .ref_clk(ref_clk), .ready_status_out(ready_status_out),
    .lane_in(lane_seen), .conv_start_select(cs_pin),
    .sclk_in(sclk_pin), .sdi_in(sdi_pin));

  // converter stand-in: a result arrives a fixed time after each start
  always @(posedge ref_clk) begin
    cdly           <= (conv_start === 1'b1) ? 5'h14 : (cdly != 5'h00 ? cdly - 5'h01 : 5'h00);
    conv_in.done   <= (cdly == 5'h01);
    conv_in.result <= 16'($random(seed));
    if (conv_in.done) last_res <= conv_in.result;
  end

  // ----------------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // hang guard, far beyond 48 frames of at most 41 edges
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      tally_and_finish();
    end
  end

  // register pair model: updates the store and prepares the next read word
  task automatic apply_cmd(input logic [31:0] c, input int len);
    logic [6:0]  p;
    logic [15:0] d;
    p     = c[23:17];
    d     = c[15:0];
    rd_ok = 1'b0;
    if (len < 32 || c[24]) return;
    case (c[31:27])
      5'h18: mem[p] = mem[p] & ~d;
      5'h1b: mem[p] = mem[p] | d;
      5'h19: if (d == 16'h0) begin rd_ok = 1'b1; rdw = {mem[p], 16'h0}; end
      5'h09: if (d == 16'h0) begin rd_ok = 1'b1; rdw = {c[16] ? mem[p][15:8] : mem[p][7:0], 24'h0}; end
      5'h1a: case (c[26:25])
        2'h0: mem[p] = d;
        2'h1: mem[p][15:8] = d[15:8];
        2'h2: mem[p][7:0] = d[7:0];
        default: ;
      endcase
      default: ;
    endcase
  endtask : apply_cmd

  // ----------------------------------------------------------------------
  // main sequence: random frames of every command, length and word source
  // ----------------------------------------------------------------------
  initial begin
    seed = 32'h171ac129;
    for (k = 0; k < 128; k++) mem[k] = 16'h0;
    rst_b = 1'b0; lane_en = 2'h1; fixed_pat_en = 1'b0; fixed_pat = 32'h0; conv_in = '0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (k = 0; k < 48; k++) begin
      r   = $random(seed);
      cmd = {ops[r[2:0]], r[4:3], r[7:5] == 3'h0, 8'($random(seed)), 16'($random(seed))};
      if (ops[r[2:0]] == 5'h00) cmd = 32'h0;
      else if (cmd[30:27] == 4'h9 && r[8]) cmd[15:0] = 16'h0;
      n     = lens[{$random(seed)} % 5];
      fp_en = r[9] && r[10];  // fixed pattern outranks a pending read
      fpat  = $random(seed);
      lane_en      <= 2'({$random(seed)} % 3 + 1);
      fixed_pat_en <= fp_en;
      fixed_pat    <= fpat;
      while (ready_status_out !== 1'b1) @(posedge ref_clk);
      exp = fp_en ? fpat : (rd_ok ? rdw : {last_res, 16'h0});
      u_host_frame_model.run_frame(cmd, n, rx);
      m    = (n < 32) ? n : 32;
      mask = ~(32'hffff_ffff >> m);
      check(rx & mask, exp & mask);
      apply_cmd(cmd, n);
      repeat (6) @(posedge ref_clk);
      #1;
      check({29'h0, ready_status_out, serial_out_oe}, 32'h0);
      @(posedge ref_clk);
    end
    tally_and_finish();
  end

endmodule : adc_serial_frame_cmd_decoder_test
`default_nettype wire
